// File: cas_pkg.sv
package cas_pkg;
    // addressing forms seen by the sequencer
    typedef enum logic [3:0] {
        CAS_FORM_REG_ONLY = 4'h0, // register_only_operand_form
        CAS_FORM_BRANCH = 4'h1, // branch_offset_form
        CAS_FORM_LITERAL = 4'h2, // literal_operand_form
        CAS_FORM_DIRECT = 4'h3,
        CAS_FORM_FULL = 4'h4, // full_address_form
        CAS_FORM_PTR = 4'h5, // pointer_no_offset_form
        CAS_FORM_PTR_INC = 4'h6, // pointer_post_increment_form
        CAS_FORM_PTR_B = 4'h7, // pointer_byte_offset_form
        CAS_FORM_PTR_B_INC = 4'h8, // pointer_byte_offset_increment_form
        CAS_FORM_PTR_W = 4'h9, // pointer_word_offset_form
        CAS_FORM_STK_B = 4'hA, // stack_byte_offset_form
        CAS_FORM_STK_W = 4'hB // stack_word_offset_form
    } cas_form_t;
    // instruction class for post-increment qualification
    typedef enum logic [1:0] {
        CAS_CLS_OTHER = 2'h0,
        CAS_CLS_COPY = 2'h1, // memory_copy_instruction
        CAS_CLS_CMPBR = 2'h2 // compare_branch_equal_instruction
    } cas_cls_t;
    localparam logic [15:0] CAS_RESET_VEC_HI = 16'hFFFE;
    localparam logic [15:0] CAS_RESET_VEC_LO = 16'hFFFF;
    localparam logic [15:0] CAS_ONE = 16'h0001;
    localparam logic [7:0] CAS_DIRECT_PAGE = 8'h00;
    localparam logic [7:0] CAS_ZERO_BYTE = 8'h00;
    localparam logic [15:0] CAS_ZERO_WORD = 16'h0000;
    localparam int CAS_MASK_BIT = 3;
    localparam logic [2:0] CAS_QUEUE_FILL = 3'h3; // program bytes refetched
    localparam logic [2:0] CAS_ZERO3 = 3'h0;
    localparam int CAS_RESET_CYCLES = 6;
endpackage : cas_pkg

// File: cas_sequencer.sv
`timescale 1ns/1ps
module cas_sequencer
    import cas_pkg::*;
(
    input wire logic mclk_i, // bus clock
    input wire logic nrst_i, // sync reset, active low
    input wire logic src_done_i, // internal reset source check finished
    input wire logic rst_pin_n_i, // external reset pin, active low
    input wire logic ea_req_i, // one-cycle request to form an address
    input wire cas_form_t form_i, // addressing form
    input wire cas_cls_t cls_i, // instruction class
    input wire logic [7:0] op_b1_i, // first byte after opcode
    input wire logic [7:0] op_b2_i, // second byte after opcode
    input wire logic br_taken_i, // branch condition holds
    input wire logic [15:0] pc_i, // program counter
    input wire logic [15:0] idx_i, // index pair (upper:lower)
    input wire logic [7:0] acc_i, // accumulator
    input wire logic [7:0] flags_i, // condition flags (mask bit overridden)
    input wire logic boundary_i, // instruction boundary reached
    input wire logic [7:0] irq_i, // pending maskable requests, bit 0 highest
    input wire logic trap_i, // soft trap instruction executing
    input wire logic wait_i, // wait instruction executing
    input wire logic dbg_halt_i, // debug halt request command
    input wire logic [7:0] rd_data_i, // bus read data
    output logic [15:0] ea_o, // effective address / literal word
    output logic ea_vld_o, // ea_o valid pulse
    output logic [15:0] pc_o, // new program counter
    output logic pc_vld_o, // pc_o valid pulse
    output logic [15:0] idx_o, // updated index pair
    output logic idx_vld_o, // idx_o valid pulse
    output logic [15:0] sp_o, // stack_top_pointer
    output logic mask_o, // interrupt mask
    output logic [15:0] bus_addr_o, // bus address
    output logic bus_rd_o, // bus read strobe
    output logic bus_wr_o, // bus write strobe
    output logic [7:0] bus_wdata_o, // bus write data
    output logic cpu_clk_en_o, // cpu clock running
    output logic bgnd_o, // active background mode
    output logic busy_o // special sequence running
);
    typedef enum logic [8:0] {
        ST_RESET = 9'b0_0000_0001,
        ST_RVEC = 9'b0_0000_0010,
        ST_RUN = 9'b0_0000_0100,
        ST_PUSH = 9'b0_0000_1000,
        ST_VEC_HI = 9'b0_0001_0000,
        ST_VEC_LO = 9'b0_0010_0000,
        ST_IDLE = 9'b0_0100_0000,
        ST_FILL = 9'b0_1000_0000,
        ST_WAIT = 9'b1_0000_0000
    } cas_state_t;

    localparam logic [15:0] IRQ_VEC_TOP = 16'hFFFC; // arbitrary top of request vectors
    localparam logic [15:0] TRAP_VEC = 16'hFFFC; // arbitrary trap vector

    cas_state_t state, next_state;
    logic [2:0] cnt, next_cnt;
    logic [15:0] sp, next_sp, vec, next_vec, ea, next_ea, pc, next_pc, idx, next_idx;
    logic [15:0] bus_addr, next_bus_addr;
    logic [7:0] wdata, next_wdata;
    logic [39:0] frame, next_frame;
    logic ea_vld, next_ea_vld, pc_vld, next_pc_vld, idx_vld, next_idx_vld;
    logic mask, next_mask, rd, next_rd, wr, next_wr, bgnd, next_bgnd;
    logic [2:0] irq_num;
    logic irq_any;
    logic [7:0] flags_stk;

    // priority encoder: lowest set bit wins
    function automatic logic [2:0] prio(input logic [7:0] r);
        logic [2:0] n;
        n = CAS_ZERO3;
        for (int i = 7; i >= 0; i--)
        begin
            if (r[i])
                n = 3'(i);
        end
        return n;
    endfunction

    assign irq_any = (|irq_i) && !mask;
    assign irq_num = prio(irq_i);

    // stacked flags carry the live mask, not the caller's stale copy
    always_comb
    begin
        flags_stk = flags_i;
        flags_stk[CAS_MASK_BIT] = mask;
    end

    // address formation and sequencing
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_sp = sp;
        next_vec = vec;
        next_ea = ea;
        next_pc = pc;
        next_idx = idx;
        next_bus_addr = bus_addr;
        next_wdata = wdata;
        next_frame = frame;
        next_ea_vld = 1'b0;
        next_pc_vld = 1'b0;
        next_idx_vld = 1'b0;
        next_mask = mask;
        next_rd = 1'b0;
        next_wr = 1'b0;
        next_bgnd = bgnd;
        case (state)
            ST_RESET:
            begin
                if (src_done_i && rst_pin_n_i)
                begin
                    next_state = ST_RVEC;
                    next_cnt = CAS_ZERO3;
                end
            end
            ST_RVEC:
            begin
                // six cycles: vector hi, vector lo, then queue fill
                next_cnt = cnt + 3'h1;
                next_rd = 1'b1;
                case (cnt)
                    3'h0: next_bus_addr = CAS_RESET_VEC_HI;
                    3'h1: next_bus_addr = CAS_RESET_VEC_LO;
                    3'h2: next_rd = 1'b0; // free cycle while the vector bytes arrive
                    default: next_bus_addr = bus_addr + CAS_ONE;
                endcase
                if (cnt == 3'h2)
                    next_pc[15:8] = rd_data_i;
                if (cnt == 3'h3)
                begin
                    next_pc[7:0] = rd_data_i;
                    next_bus_addr = {pc[15:8], rd_data_i};
                end
                if (cnt == 3'(CAS_RESET_CYCLES - 1))
                begin
                    next_state = ST_RUN;
                    next_pc_vld = 1'b1; // third fill read still issues on this edge
                end
            end
            ST_RUN:
            begin
                if (ea_req_i)
                begin
                    next_ea_vld = 1'b1;
                    case (form_i)
                        CAS_FORM_BRANCH: next_ea = br_taken_i ?
                            pc_i + {{8{op_b1_i[7]}}, op_b1_i} : pc_i;
                        CAS_FORM_LITERAL, CAS_FORM_FULL, CAS_FORM_PTR_W, CAS_FORM_STK_W:
                            next_ea = {op_b1_i, op_b2_i};
                        CAS_FORM_DIRECT: next_ea = {CAS_DIRECT_PAGE, op_b1_i};
                        CAS_FORM_PTR, CAS_FORM_PTR_INC: next_ea = idx_i;
                        CAS_FORM_PTR_B, CAS_FORM_PTR_B_INC:
                            next_ea = idx_i + {CAS_ZERO_BYTE, op_b1_i};
                        default: next_ea = CAS_ZERO_WORD;
                    endcase
                    if (form_i == CAS_FORM_PTR_W)
                        next_ea = idx_i + {op_b1_i, op_b2_i};
                    if (form_i == CAS_FORM_STK_B)
                        next_ea = sp + {CAS_ZERO_BYTE, op_b1_i};
                    if (form_i == CAS_FORM_STK_W)
                        next_ea = sp + {op_b1_i, op_b2_i};
                    // post-increment only for the qualifying classes
                    if ((form_i == CAS_FORM_PTR_INC && cls_i != CAS_CLS_OTHER) ||
                        (form_i == CAS_FORM_PTR_B_INC && cls_i == CAS_CLS_CMPBR))
                    begin
                        next_idx = idx_i + CAS_ONE;
                        next_idx_vld = 1'b1;
                    end
                end
                if (boundary_i && (trap_i || irq_any))
                begin
                    next_vec = trap_i ? TRAP_VEC : IRQ_VEC_TOP - {12'h000, irq_num, 1'b0};
                    // upper index byte deliberately left out of the frame
                    next_frame = {pc_i[7:0], pc_i[15:8], idx_i[7:0], acc_i, flags_stk};
                    next_cnt = CAS_ZERO3;
                    next_state = ST_PUSH;
                end
                else if (boundary_i && wait_i)
                begin
                    next_mask = 1'b0;
                    next_state = ST_WAIT;
                end
            end
            ST_PUSH:
            begin
                next_bus_addr = sp;
                next_wdata = frame[39:32];
                next_frame = {frame[31:0], CAS_ZERO_BYTE};
                next_wr = 1'b1;
                next_sp = sp - CAS_ONE;
                next_cnt = cnt + 3'h1;
                if (cnt == 3'h4)
                begin
                    next_mask = 1'b1;
                    next_state = ST_VEC_HI;
                end
            end
            ST_VEC_HI:
            begin
                next_bus_addr = vec;
                next_rd = 1'b1;
                next_state = ST_VEC_LO;
            end
            ST_VEC_LO:
            begin
                next_bus_addr = vec + CAS_ONE;
                next_rd = 1'b1;
                next_state = ST_IDLE;
            end
            ST_IDLE:
            begin
                // free bus cycle; the high vector byte arrives now
                next_pc[15:8] = rd_data_i;
                next_cnt = CAS_ZERO3;
                next_state = ST_FILL;
            end
            ST_FILL:
            begin
                next_bus_addr = pc + {13'h0000, cnt};
                // low vector byte arrives with the first fill request
                if (cnt == CAS_ZERO3)
                begin
                    next_pc[7:0] = rd_data_i;
                    next_bus_addr = {pc[15:8], rd_data_i};
                end
                next_rd = 1'b1;
                next_cnt = cnt + 3'h1;
                if (cnt == CAS_QUEUE_FILL - 3'h1)
                begin
                    next_pc_vld = 1'b1;
                    next_state = ST_RUN;
                end
            end
            ST_WAIT:
            begin
                if (dbg_halt_i)
                begin
                    next_bgnd = 1'b1;
                    next_state = ST_RUN;
                end
                else if (|irq_i)
                    next_state = ST_RUN;
            end
            default: next_state = ST_RESET;
        endcase
    end

    // state registers; reset is synchronous and overrides any sequence
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            state <= ST_RESET;
            cnt <= CAS_ZERO3;
            sp <= CAS_ZERO_WORD;
            vec <= CAS_ZERO_WORD;
            ea <= CAS_ZERO_WORD;
            pc <= CAS_ZERO_WORD;
            idx <= CAS_ZERO_WORD;
            bus_addr <= CAS_ZERO_WORD;
            wdata <= CAS_ZERO_BYTE;
            frame <= 40'h00_0000_0000;
            ea_vld <= 1'b0;
            pc_vld <= 1'b0;
            idx_vld <= 1'b0;
            mask <= 1'b1;
            rd <= 1'b0;
            wr <= 1'b0;
            bgnd <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            sp <= next_sp;
            vec <= next_vec;
            ea <= next_ea;
            pc <= next_pc;
            idx <= next_idx;
            bus_addr <= next_bus_addr;
            wdata <= next_wdata;
            frame <= next_frame;
            ea_vld <= next_ea_vld;
            pc_vld <= next_pc_vld;
            idx_vld <= next_idx_vld;
            mask <= next_mask;
            rd <= next_rd;
            wr <= next_wr;
            bgnd <= next_bgnd;
        end
    end

    // registered outputs
    logic clk_en;
    logic busy;
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            clk_en <= 1'b1;
            busy <= 1'b0;
        end
        else
        begin
            clk_en <= (next_state != ST_WAIT);
            busy <= (next_state != ST_RUN) && (next_state != ST_WAIT);
        end
    end
    always_comb
    begin
        ea_o = ea;
        ea_vld_o = ea_vld;
        pc_o = pc;
        pc_vld_o = pc_vld;
        idx_o = idx;
        idx_vld_o = idx_vld;
        sp_o = sp;
        mask_o = mask;
        bus_addr_o = bus_addr;
        bus_rd_o = rd;
        bus_wr_o = wr;
        bus_wdata_o = wdata;
        cpu_clk_en_o = clk_en;
        bgnd_o = bgnd;
        busy_o = busy;
    end

    property p_direct_page;
        @(posedge mclk_i) disable iff (!nrst_i)
        (state == ST_RUN && ea_req_i && form_i == CAS_FORM_DIRECT) |=> ea_o[15:8] == 8'h00;
    endproperty
    a_direct_page: assert property (p_direct_page) else $error("direct page high byte");

    property p_no_inc_other;
        @(posedge mclk_i) disable iff (!nrst_i)
        (state == ST_RUN && ea_req_i && cls_i == CAS_CLS_OTHER) |=> !idx_vld_o;
    endproperty
    a_no_inc_other: assert property (p_no_inc_other) else $error("bad increment");

    property p_push_dec;
        @(posedge mclk_i) disable iff (!nrst_i)
        (state == ST_PUSH) |=> bus_wr_o && sp_o == $past(sp_o) - 16'h0001;
    endproperty
    a_push_dec: assert property (p_push_dec) else $error("stack not decremented");

    property p_mask_after_push;
        @(posedge mclk_i) disable iff (!nrst_i)
        $rose(state == ST_PUSH) |-> ##5 mask_o ##1 bus_rd_o;
    endproperty
    a_mask_after_push: assert property (p_mask_after_push) else $error("mask not set");

    property p_wait_mask;
        @(posedge mclk_i) disable iff (!nrst_i)
        (state == ST_WAIT) |-> !mask_o && !cpu_clk_en_o;
    endproperty
    a_wait_mask: assert property (p_wait_mask) else $error("wait mask or clock");

    property p_masked_ignored;
        @(posedge mclk_i) disable iff (!nrst_i)
        (state == ST_RUN && mask && !trap_i) |=> state != ST_PUSH;
    endproperty
    a_masked_ignored: assert property (p_masked_ignored) else $error("masked irq taken");

    property p_trap_unmasked;
        @(posedge mclk_i) disable iff (!nrst_i)
        (state == ST_RUN && boundary_i && trap_i) |=> state == ST_PUSH;
    endproperty
    a_trap_unmasked: assert property (p_trap_unmasked) else $error("trap not taken");

    property p_reset_len;
        @(posedge mclk_i) disable iff (!nrst_i)
        $rose(state == ST_RVEC) |-> (state == ST_RVEC) [*6] ##1 state == ST_RUN;
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("reset sequence length");

    property p_dbg_wake;
        @(posedge mclk_i) disable iff (!nrst_i)
        (state == ST_WAIT && dbg_halt_i) |=> bgnd_o && cpu_clk_en_o;
    endproperty
    a_dbg_wake: assert property (p_dbg_wake) else $error("debug wake");
endmodule // cas_sequencer

// File: cas_mem_model.sv
`timescale 1ns/1ps
module cas_mem_model
    import cas_pkg::*;
(
    input wire logic mclk_i, // bus clock
    input wire logic [15:0] bus_addr_i, // bus address
    input wire logic bus_rd_i, // read strobe
    input wire logic bus_wr_i, // write strobe
    input wire logic [7:0] bus_wdata_i, // write data
    output logic [7:0] rd_data_o // read data, one cycle after the strobe
);
    logic [7:0] mem [logic [15:0]];
    logic [24:0] log_q [$]; // {write, address, data} of every access
    // byte at an address, a fixed pattern where nothing was written
    function automatic logic [7:0] peek(input logic [15:0] a);
        if (mem.exists(a))
        begin
            return mem[a];
        end
        return a[7:0] ^ 8'h5A;
    endfunction
    // vectors: reset, soft trap, request line 2
    initial
    begin
        mem[16'hFFFE] = 8'h80;
        mem[16'hFFFF] = 8'h00;
        mem[16'hFFFC] = 8'h90;
        mem[16'hFFFD] = 8'h10;
        mem[16'hFFF8] = 8'hA0;
        mem[16'hFFF9] = 8'h20;
    end
    // answer a read next cycle; otherwise toggle so stale data never looks valid
    always @(posedge mclk_i)
    begin
        if (bus_rd_i)
        begin
            rd_data_o <= peek(bus_addr_i);
            log_q.push_back({1'b0, bus_addr_i, 8'h00});
        end
        else
        begin
            rd_data_o <= ~rd_data_o;
        end
        if (bus_wr_i)
        begin
            // program memory from 8000 up is read-only, so a wrapped stack keeps the vectors
            if (bus_addr_i < 16'h8000)
                mem[bus_addr_i] = bus_wdata_i;
            log_q.push_back({1'b1, bus_addr_i, bus_wdata_i});
        end
    end
endmodule // cas_mem_model

// File: cas_sequencer_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
`define WAITFOR(nm, c, lim) begin for (int k = 0; k < lim && (c) !== 1'b1; k++) \
    @(negedge mclk_i); `CHK(nm, 1'b1, c) if ((c) !== 1'b1) give_verdict(); end
module cas_sequencer_tb;
    import cas_pkg::*;
    typedef struct {
        cas_form_t f;
        cas_cls_t c;
        logic [7:0] b1, b2;
        logic [15:0] pc, ix, ea;
        logic ck, inc;
        logic [15:0] nix;
    } cas_row_t;
    logic mclk_i = 1'b0;
    logic nrst_i, src_done_i, rst_pin_n_i, ea_req_i, br_taken_i, boundary_i;
    logic trap_i, wait_i, dbg_halt_i, ea_vld_o, pc_vld_o, idx_vld_o, mask_o;
    logic bus_rd_o, bus_wr_o, cpu_clk_en_o, bgnd_o, busy_o;
    cas_form_t form_i;
    cas_cls_t cls_i;
    logic [7:0] op_b1_i, op_b2_i, acc_i, flags_i, irq_i, rd_data_i, bus_wdata_o;
    logic [15:0] pc_i, idx_i, ea_o, pc_o, idx_o, sp_o, bus_addr_o;
    int miscompares = 0;
    int tests_run = 0;
    // address forms: inputs and the address or pointer they must give
    cas_row_t rows [14] = '{
        '{CAS_FORM_BRANCH, CAS_CLS_OTHER, 8'h80, 8'h00, 16'h1000, 0, 16'h0F80, 1, 0, 0},
        '{CAS_FORM_BRANCH, CAS_CLS_OTHER, 8'h7F, 8'h00, 16'hFFF0, 0, 16'h006F, 1, 0, 0},
        '{CAS_FORM_LITERAL, CAS_CLS_OTHER, 8'h12, 8'h34, 0, 0, 16'h1234, 1, 0, 0},
        '{CAS_FORM_DIRECT, CAS_CLS_OTHER, 8'hA5, 8'h77, 0, 16'h9999, 16'h00A5, 1, 0, 0},
        '{CAS_FORM_FULL, CAS_CLS_OTHER, 8'hBE, 8'hEF, 0, 0, 16'hBEEF, 1, 0, 0},
        '{CAS_FORM_PTR, CAS_CLS_COPY, 8'h11, 8'h22, 0, 16'h1234, 16'h1234, 1, 0, 0},
        '{CAS_FORM_PTR_INC, CAS_CLS_COPY, 0, 0, 0, 16'hFFFF, 16'hFFFF, 1, 1, 16'h0000},
        '{CAS_FORM_PTR_INC, CAS_CLS_CMPBR, 0, 0, 0, 16'h2000, 16'h2000, 1, 1, 16'h2001},
        '{CAS_FORM_PTR_INC, CAS_CLS_OTHER, 0, 0, 0, 16'h2000, 0, 0, 0, 0},
        '{CAS_FORM_PTR_B, CAS_CLS_OTHER, 8'hF0, 0, 0, 16'h1000, 16'h10F0, 1, 0, 0},
        '{CAS_FORM_PTR_B_INC, CAS_CLS_CMPBR, 8'h80, 0, 0, 16'h1000, 16'h1080, 1, 1, 16'h1001},
        '{CAS_FORM_PTR_B_INC, CAS_CLS_COPY, 8'h80, 0, 0, 16'h1000, 0, 0, 0, 0},
        '{CAS_FORM_PTR_W, CAS_CLS_OTHER, 8'h90, 8'h10, 0, 16'h8000, 16'h1010, 1, 0, 0},
        '{CAS_FORM_STK_B, CAS_CLS_OTHER, 8'hFF, 8'h01, 0, 16'h4444, 16'h00FF, 1, 0, 0}
    };
    cas_sequencer dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .src_done_i(src_done_i),
        .rst_pin_n_i(rst_pin_n_i), .ea_req_i(ea_req_i), .form_i(form_i), .cls_i(cls_i),
        .op_b1_i(op_b1_i), .op_b2_i(op_b2_i), .br_taken_i(br_taken_i), .pc_i(pc_i),
        .idx_i(idx_i), .acc_i(acc_i), .flags_i(flags_i), .boundary_i(boundary_i),
        .irq_i(irq_i), .trap_i(trap_i), .wait_i(wait_i), .dbg_halt_i(dbg_halt_i),
        .rd_data_i(rd_data_i), .ea_o(ea_o), .ea_vld_o(ea_vld_o), .pc_o(pc_o),
        .pc_vld_o(pc_vld_o), .idx_o(idx_o), .idx_vld_o(idx_vld_o), .sp_o(sp_o),
        .mask_o(mask_o), .bus_addr_o(bus_addr_o), .bus_rd_o(bus_rd_o), .bus_wr_o(bus_wr_o),
        .bus_wdata_o(bus_wdata_o), .cpu_clk_en_o(cpu_clk_en_o), .bgnd_o(bgnd_o),
        .busy_o(busy_o));
    cas_mem_model u_mem (.mclk_i(mclk_i), .bus_addr_i(bus_addr_o), .bus_rd_i(bus_rd_o),
        .bus_wr_i(bus_wr_o), .bus_wdata_i(bus_wdata_o), .rd_data_o(rd_data_i));
    // 250 MHz bus clock
    always #2 mclk_i = ~mclk_i;
    // counts, verdict and end of run
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // reset with the pin held past the source check, then the vector fetch
    task automatic do_reset();
        @(negedge mclk_i);
        nrst_i = 1'b0;
        src_done_i = 1'b0;
        rst_pin_n_i = 1'b0;
        @(negedge mclk_i);
        `CHK("busy_rst", 1'b0, busy_o)
        `CHK("wr_rst", 1'b0, bus_wr_o)
        repeat (5) @(negedge mclk_i);
        `CHK("mask_rst", 1'b1, mask_o)
        `CHK("bgnd_rst", 1'b0, bgnd_o)
        `CHK("sp_rst", 16'h0000, sp_o)
        nrst_i = 1'b1;
        rst_pin_n_i = 1'b1;
        u_mem.log_q.delete();
        repeat (4) @(negedge mclk_i);
        `CHK("src_wait", 0, u_mem.log_q.size())
        rst_pin_n_i = 1'b0;
        src_done_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        `CHK("pin_held", 0, u_mem.log_q.size())
        rst_pin_n_i = 1'b1;
        `WAITFOR("rvec_done", pc_vld_o, 12)
        `CHK("rvec_pc", 16'h8000, pc_o)
        `CHK("rvec_hi", {1'b0, 16'hFFFE, 8'h00}, u_mem.log_q[0])
        `CHK("rvec_lo", {1'b0, 16'hFFFF, 8'h00}, u_mem.log_q[1])
        `CHK("rvec_fill", {1'b0, 16'h8000, 8'h00}, u_mem.log_q[2])
        @(negedge mclk_i);
        `CHK("rvec_n", 5, u_mem.log_q.size())
        `CHK("rvec_last", {1'b0, 16'h8002, 8'h00}, u_mem.log_q[4])
    endtask
    // one boundary pulse carrying the given instruction flags
    task automatic at_boundary(input logic tr, input logic wt);
        @(negedge mclk_i);
        trap_i = tr;
        wait_i = wt;
        boundary_i = 1'b1;
        @(negedge mclk_i);
        boundary_i = 1'b0;
        trap_i = 1'b0;
        wait_i = 1'b0;
    endtask
    // stacking order, vector, queue fill and mask after a service entry
    task automatic check_svc(input logic [15:0] vec, tgt, sp0, input logic [7:0] fl);
        logic [7:0] pb [5];
        pb = '{8'h21, 8'h43, 8'h66, 8'h77, fl};
        `WAITFOR("svc_done", pc_vld_o, 30)
        @(negedge mclk_i); // the last fill read is taken one edge after pc_vld_o
        `CHK("svc_n", 10, u_mem.log_q.size())
        for (int i = 0; i < 5; i++)
            `CHK("push", {1'b1, sp0 - 16'(i), pb[i]}, u_mem.log_q[i])
        `CHK("vec_hi", {1'b0, vec, 8'h00}, u_mem.log_q[5])
        `CHK("vec_lo", {1'b0, vec + 16'h0001, 8'h00}, u_mem.log_q[6])
        for (int i = 0; i < 3; i++)
            `CHK("fill", {1'b0, tgt + 16'(i), 8'h00}, u_mem.log_q[7 + i])
        `CHK("svc_pc", tgt, pc_o)
        `CHK("svc_sp", sp0 - 16'h0005, sp_o)
        `CHK("svc_mask", 1'b1, mask_o)
    endtask
    initial
    begin
        {nrst_i, src_done_i, rst_pin_n_i, ea_req_i, boundary_i, trap_i, wait_i} = '0;
        {dbg_halt_i, irq_i, op_b1_i, op_b2_i, pc_i, idx_i} = '0;
        form_i = CAS_FORM_REG_ONLY;
        cls_i = CAS_CLS_OTHER;
        br_taken_i = 1'b1;
        acc_i = 8'h77;
        flags_i = 8'hC5;
        do_reset();
        foreach (rows[r])
        begin
            @(negedge mclk_i);
            form_i = rows[r].f;
            cls_i = rows[r].c;
            {op_b1_i, op_b2_i} = {rows[r].b1, rows[r].b2};
            {pc_i, idx_i} = {rows[r].pc, rows[r].ix};
            ea_req_i = 1'b1;
            @(negedge mclk_i);
            ea_req_i = 1'b0;
            `CHK("ea_vld", 1'b1, ea_vld_o)
            if (rows[r].ck)
                `CHK("ea", rows[r].ea, ea_o)
            `CHK("idx_vld", rows[r].inc, idx_vld_o)
            if (rows[r].inc)
                `CHK("idx", rows[r].nix, idx_o)
        end
        // word stack offset FFFE added to a stack pointer still at 0000
        @(negedge mclk_i);
        form_i = CAS_FORM_STK_W;
        {op_b1_i, op_b2_i} = {8'hFF, 8'hFE};
        ea_req_i = 1'b1;
        @(negedge mclk_i);
        ea_req_i = 1'b0;
        `CHK("ea_stkw", 16'hFFFE, ea_o)
        // branch not taken leaves the program counter as it is
        @(negedge mclk_i);
        form_i = CAS_FORM_BRANCH;
        {op_b1_i, br_taken_i, pc_i} = {8'h10, 1'b0, 16'h1234};
        ea_req_i = 1'b1;
        @(negedge mclk_i);
        ea_req_i = 1'b0;
        br_taken_i = 1'b1;
        `CHK("ea_nt", 16'h1234, ea_o)
        {pc_i, idx_i} = {16'h4321, 16'h5566};
        u_mem.log_q.delete();
        irq_i = 8'h01;
        at_boundary(1'b0, 1'b0);
        repeat (4) @(negedge mclk_i);
        `CHK("masked", 0, u_mem.log_q.size())
        irq_i = 8'h00;
        at_boundary(1'b1, 1'b0);
        check_svc(16'hFFFC, 16'h9010, 16'h0000, 8'hCD);
        at_boundary(1'b0, 1'b1);
        `CHK("wait_mask", 1'b0, mask_o)
        `CHK("wait_clk", 1'b0, cpu_clk_en_o)
        ea_req_i = 1'b1;
        @(negedge mclk_i);
        ea_req_i = 1'b0;
        `CHK("wait_ea", 1'b0, ea_vld_o)
        u_mem.log_q.delete();
        irq_i = 8'b0010_0100;
        `WAITFOR("wake", cpu_clk_en_o, 8)
        repeat (2) @(negedge mclk_i);
        if (busy_o !== 1'b1)
            at_boundary(1'b0, 1'b0);
        check_svc(16'hFFF8, 16'hA020, 16'hFFFB, 8'hC5);
        irq_i = 8'h00;
        at_boundary(1'b0, 1'b1);
        dbg_halt_i = 1'b1;
        @(negedge mclk_i);
        dbg_halt_i = 1'b0;
        `WAITFOR("bgnd", bgnd_o, 8)
        `CHK("bgnd_clk", 1'b1, cpu_clk_en_o)
        at_boundary(1'b1, 1'b0);
        do_reset();
        give_verdict();
    end
endmodule // cas_sequencer_tb
